// ===== hw/arwd_defines.vh
// Register offsets, reset values and field positions of the result formatter and window detector
`ifndef ARWD_DEFINES_VH
`define ARWD_DEFINES_VH
`define ARWD_ADDR_W          8
`define ARWD_OFF_SAR_CFG     8'hBC
`define ARWD_OFF_RES_LOW     8'hBE
`define ARWD_OFF_RES_HIGH    8'hBF
`define ARWD_OFF_PAIR_CFG    8'hBA
`define ARWD_OFF_GT_LOW      8'hC4
`define ARWD_OFF_GT_HIGH     8'hC5
`define ARWD_OFF_LT_LOW      8'hC6
`define ARWD_OFF_LT_HIGH     8'hC7
`define ARWD_OFF_CTRL        8'hE8
`define ARWD_RST_SAR_CFG     8'hF8
`define ARWD_RST_GT_LOW      8'hFF
`define ARWD_RST_GT_HIGH     8'hFF
`define ARWD_RST_LT_LOW      8'h00
`define ARWD_RST_LT_HIGH     8'h00
`define ARWD_RST_ZERO8       8'h00
`define ARWD_BIT_ENABLE      7
`define ARWD_BIT_DONE        5
`define ARWD_BIT_BUSY        4
`define ARWD_BIT_WIN         1
`define ARWD_BIT_LJ          0
`define ARWD_SC_MSB          7
`define ARWD_SC_LSB          3
`define ARWD_CONV_SAR_CLKS   16
`endif

// ===== hw/arwd_sar_timer.v
// Conversion sequencer: counts SAR clock periods derived from the system clock
`timescale 1ns/10ps
`default_nettype none
`include "arwd_defines.vh"
module arwd_sar_timer #(
  parameter CONV_CLKS = `ARWD_CONV_SAR_CLKS
) (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       start,
  input  wire [4:0] sar_div,
  output reg        busy_q,
  output reg        done_q
);
  reg  [4:0] div_q;
  reg  [5:0] per_q;
  wire       sar_tick = (div_q == sar_div);

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_q  <= 5'h00;
      per_q  <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        div_q <= 5'h00;
        per_q <= 6'h00;
        if (start) begin
          busy_q <= 1'b1;
        end
      end else begin
        div_q <= sar_tick ? 5'h00 : div_q + 5'h01;
        if (sar_tick) begin
          // Result lands only after the full count of SAR periods
          if (per_q == CONV_CLKS[5:0] - 6'h01) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            per_q <= per_q + 6'h01;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/arwd_top.v
// Result formatter, window detector and control registers of the 12-bit converter
`timescale 1ns/10ps
`default_nettype none
`include "arwd_defines.vh"
module arwd_top #(
  parameter CONV_CLKS = `ARWD_CONV_SAR_CLKS
) (
  input  wire                     sys_clk,
  input  wire                     nrst,
  input  wire [`ARWD_ADDR_W-1:0]  reg_addr,
  input  wire                     reg_wr,
  input  wire [7:0]               reg_wdata,
  output reg  [7:0]               reg_rdata,
  input  wire [11:0]              sar_code,
  input  wire                     diff_mode,
  output reg                      conv_done_irq,
  output reg                      window_irq
);
  reg  [7:0]  sar_cfg_q;
  reg  [7:0]  pair_cfg_q;
  reg         enable_q;
  reg         conversion_complete_flag_q;
  reg         window_match_flag_q;
  reg         left_justify_select_q;
  reg  [7:0]  ctrl_misc_q;
  reg  [7:0]  result_high_byte_q;
  reg  [7:0]  result_low_byte_q;
  reg  [7:0]  gt_low_q;
  reg  [7:0]  gt_high_q;
  reg  [7:0]  lt_low_q;
  reg  [7:0]  lt_high_q;
  reg  [11:0] code_s1_q;
  reg  [11:0] code_s2_q;
  reg         diff_s1_q;
  reg         diff_s2_q;
  reg  [15:0] pair_d;
  reg         match_d;
  wire        conversion_in_progress;
  wire        conv_done;
  wire        wr_ctrl = reg_wr && (reg_addr == `ARWD_OFF_CTRL);
  wire        start = wr_ctrl && reg_wdata[`ARWD_BIT_BUSY] && enable_q;
  wire [15:0] gt_word = {gt_high_q, gt_low_q};
  wire [15:0] lt_word = {lt_high_q, lt_low_q};

  arwd_sar_timer #(
    .CONV_CLKS (CONV_CLKS)
  ) u_timer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .start   (start),
    .sar_div (sar_cfg_q[`ARWD_SC_MSB:`ARWD_SC_LSB]),
    .busy_q  (conversion_in_progress),
    .done_q  (conv_done)
  );

  // Format the synchronised code and decide the window match
  always @* begin
    if (left_justify_select_q) begin
      pair_d = {code_s2_q, 4'h0};
    end else begin
      pair_d = {(diff_s2_q ? {4{code_s2_q[11]}} : 4'h0), code_s2_q};
    end
    // Greater than gt or less than lt; lt above gt flags inside, else outside
    if (diff_s2_q) begin
      match_d = ($signed(pair_d) > $signed(gt_word)) || ($signed(pair_d) < $signed(lt_word));
    end else begin
      match_d = (pair_d > gt_word) || (pair_d < lt_word);
    end
    if ($signed(lt_word) > $signed(gt_word) && diff_s2_q) begin
      match_d = ($signed(pair_d) > $signed(gt_word)) && ($signed(pair_d) < $signed(lt_word));
    end else if (lt_word > gt_word && !diff_s2_q) begin
      match_d = (pair_d > gt_word) && (pair_d < lt_word);
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sar_cfg_q                  <= `ARWD_RST_SAR_CFG;
      pair_cfg_q                 <= `ARWD_RST_ZERO8;
      enable_q                   <= 1'b0;
      conversion_complete_flag_q <= 1'b0;
      window_match_flag_q        <= 1'b0;
      left_justify_select_q      <= 1'b0;
      ctrl_misc_q                <= `ARWD_RST_ZERO8;
      result_high_byte_q         <= `ARWD_RST_ZERO8;
      result_low_byte_q          <= `ARWD_RST_ZERO8;
      gt_low_q                   <= `ARWD_RST_GT_LOW;
      gt_high_q                  <= `ARWD_RST_GT_HIGH;
      lt_low_q                   <= `ARWD_RST_LT_LOW;
      lt_high_q                  <= `ARWD_RST_LT_HIGH;
      code_s1_q                  <= 12'h000;
      code_s2_q                  <= 12'h000;
      diff_s1_q                  <= 1'b0;
      diff_s2_q                  <= 1'b0;
      conv_done_irq              <= 1'b0;
      window_irq                 <= 1'b0;
      reg_rdata                  <= `ARWD_RST_ZERO8;
    end else begin
      code_s1_q <= sar_code;
      code_s2_q <= code_s1_q;
      diff_s1_q <= diff_mode;
      diff_s2_q <= diff_s1_q;
      if (reg_wr) begin
        case (reg_addr)
          `ARWD_OFF_SAR_CFG:  sar_cfg_q <= reg_wdata;
          `ARWD_OFF_PAIR_CFG: pair_cfg_q <= {4'h0, reg_wdata[3:0]};
          `ARWD_OFF_RES_LOW:  result_low_byte_q <= reg_wdata;
          `ARWD_OFF_RES_HIGH: result_high_byte_q <= reg_wdata;
          `ARWD_OFF_GT_LOW:   gt_low_q <= reg_wdata;
          `ARWD_OFF_GT_HIGH:  gt_high_q <= reg_wdata;
          `ARWD_OFF_LT_LOW:   lt_low_q <= reg_wdata;
          `ARWD_OFF_LT_HIGH:  lt_high_q <= reg_wdata;
          default:            ;
        endcase
      end
      if (wr_ctrl) begin
        enable_q              <= reg_wdata[`ARWD_BIT_ENABLE];
        left_justify_select_q <= reg_wdata[`ARWD_BIT_LJ];
        ctrl_misc_q           <= {1'b0, reg_wdata[6], 2'b00, reg_wdata[3:2], 2'b00};
      end
      // Hardware set wins over a software write in the same cycle
      if (conv_done) begin
        conversion_complete_flag_q <= 1'b1;
      end else if (wr_ctrl) begin
        conversion_complete_flag_q <= reg_wdata[`ARWD_BIT_DONE];
      end
      if (conv_done && match_d) begin
        window_match_flag_q <= 1'b1;
      end else if (wr_ctrl) begin
        window_match_flag_q <= window_match_flag_q & reg_wdata[`ARWD_BIT_WIN];
      end
      if (conv_done) begin
        result_high_byte_q <= pair_d[15:8];
        result_low_byte_q  <= pair_d[7:0];
      end
      conv_done_irq <= conversion_complete_flag_q || conv_done;
      window_irq    <= window_match_flag_q || (conv_done && match_d);
      case (reg_addr)
        `ARWD_OFF_SAR_CFG:  reg_rdata <= sar_cfg_q;
        `ARWD_OFF_PAIR_CFG: reg_rdata <= pair_cfg_q;
        `ARWD_OFF_RES_LOW:  reg_rdata <= result_low_byte_q;
        `ARWD_OFF_RES_HIGH: reg_rdata <= result_high_byte_q;
        `ARWD_OFF_GT_LOW:   reg_rdata <= gt_low_q;
        `ARWD_OFF_GT_HIGH:  reg_rdata <= gt_high_q;
        `ARWD_OFF_LT_LOW:   reg_rdata <= lt_low_q;
        `ARWD_OFF_LT_HIGH:  reg_rdata <= lt_high_q;
        `ARWD_OFF_CTRL:     reg_rdata <= ctrl_misc_q | {enable_q, 1'b0, conversion_complete_flag_q,
                                         conversion_in_progress, 2'b00, window_match_flag_q,
                                         left_justify_select_q};
        default:            reg_rdata <= `ARWD_RST_ZERO8;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verification/arwd_top_properties.sv
// Port checker of the result formatter and window detector
`timescale 1ns/10ps
`default_nettype none
module arwd_chk #(parameter CONV_CLKS = 16) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        conv_done_irq,
  input wire logic        window_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire ctl_wr = reg_wr && reg_addr == 8'hE8;
  wire start  = ctl_wr && reg_wdata[7] && reg_wdata[4];
  chk_win_hold: assert property (window_irq && !ctl_wr && !$past(ctl_wr) |=> window_irq)
    else $error("window flag dropped");
  chk_done_hold: assert property (conv_done_irq && !ctl_wr && !$past(ctl_wr) |=> conv_done_irq)
    else $error("done flag dropped");
  chk_conv_min: assert property (start && !conv_done_irq |=> (!conv_done_irq)[*8] ##8 !conv_done_irq)
    else $error("conversion too short");
  chk_conv_end: assert property (start && !conv_done_irq |=> ##[1:600] conv_done_irq)
    else $error("conversion never ends");
  chk_gt_readback: assert property ((reg_wr && reg_addr == 8'hC5) ##1 (reg_addr == 8'hC5 && !reg_wr)[*3]
    |-> reg_rdata == $past(reg_wdata, 3)) else $error("limit byte lost");
  chk_win_cause: assert property ($rose(window_irq) |-> conv_done_irq)
    else $error("window flag without result");
  chk_win_view: assert property ((reg_addr == 8'hE8 && !reg_wr && $stable(window_irq))[*3]
    |-> reg_rdata[1] == window_irq) else $error("window flag unreadable");
  chk_done_view: assert property ((reg_addr == 8'hE8 && !reg_wr && $stable(conv_done_irq))[*3]
    |-> reg_rdata[5] == conv_done_irq) else $error("done flag unreadable");
endmodule
bind arwd_top arwd_chk #(.CONV_CLKS(CONV_CLKS)) u_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done_irq(conv_done_irq),
  .window_irq(window_irq));
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench of the result formatter and window detector
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %h seen %h", n, e, g); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [11:0] sar_code = 12'h000;
  logic        diff_mode = 1'b0;
  wire [7:0]   reg_rdata;
  wire         conv_done_irq;
  wire         window_irq;
  int          error_cnt = 0;
  int          check_count = 0;
  int          k;
  int          t;
  logic [31:0] seed = 32'hAFDB6222;
  logic [7:0]  v;
  logic [15:0] gt, lt, x;
  logic        lj, m;
  logic [7:0]  ra [10] = '{8'hBC, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hE8, 8'hBE, 8'hBF, 8'hBA, 8'h00};
  logic [7:0]  rs [10] = '{8'hF8, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #12.5 sys_clk = ~sys_clk;
  arwd_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sar_code(sar_code), .diff_mode(diff_mode), .conv_done_irq(conv_done_irq),
    .window_irq(window_irq));
  task automatic step();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endtask
  function automatic int sv(input logic [15:0] w, input logic d);
    return d ? int'($signed(w)) : int'(w);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1 v = reg_rdata;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    for (k = 0; k < 10; k++) begin
      rd(ra[k]);
      `CHK("reset value", rs[k], v)
    end
    $display("reset test done");
    wr(8'hBC, 8'h00);
    wr(8'hE8, 8'h80);
    for (k = 0; k < 10; k++) begin
      step();
      @(posedge sys_clk);
      sar_code <= seed[11:0];
      diff_mode <= seed[12];
      lj = seed[13];
      gt = seed[31:16];
      step();
      lt = seed[15:0];
      wr(8'hC4, gt[7:0]);
      wr(8'hC6, lt[7:0]);
      wr(8'hC7, lt[15:8]);
      wr(8'hC5, gt[15:8]);
      rd(8'hC5);
      `CHK("gt high", gt[15:8], v)
      wr(8'hE8, 8'h90 | lj);
      for (t = 0; t < 600 && conv_done_irq !== 1'b1; t++) begin
        @(posedge sys_clk);
        #1;
      end
      if (t == 600) begin
        error_cnt++;
        wrap_up();
      end
      @(posedge sys_clk);
      #1 x = lj ? {sar_code, 4'h0} : {diff_mode ? {4{sar_code[11]}} : 4'h0, sar_code};
      m = sv(lt, diff_mode) > sv(gt, diff_mode) ?
          (sv(x, diff_mode) > sv(gt, diff_mode) && sv(x, diff_mode) < sv(lt, diff_mode)) :
          (sv(x, diff_mode) > sv(gt, diff_mode) || sv(x, diff_mode) < sv(lt, diff_mode));
      `CHK("window", m, window_irq)
      rd(8'hBF);
      `CHK("result high", x[15:8], v)
      rd(8'hBE);
      `CHK("result low", x[7:0], v)
      rd(8'hE8);
      `CHK("control", {6'b101000, m, lj}, v)
      wr(8'hE8, 8'h80 | lj);
      rd(8'hE8);
      `CHK("window cleared", 1'b0, window_irq)
      $display("test %0d done", k);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
